// ---- rtl/gcs_map.svh ----
// Purpose: constants for the pin clock and chained select block
// Assumes: 100 MHz system clock i_clk, synchronous active-high reset
// Notes:   seven pins, clock pin is index 4
// Function
// RULE1 - internal 1 MHz master clock, divided down to a 125 kHz chopping clock
// RULE2 - clock out needs pin 4 output, clock out enable set, clock in clear
// RULE3 - clock select 1 gives 125 kHz on the pin, 0 gives 1 MHz
// RULE4 - clock in needs pin 4 input, clock in enable set, clock out clear
// RULE5 - external clock must lie between 1 MHz and 32 MHz
// RULE6 - external clock divided by programmed value to reach 1 MHz
// RULE7 - polarity 1 syncs on rising edge, 0 on falling edge
// RULE8 - chained pin enabled by making it output, then setting its mask bit
// RULE9 - mask bit ignored on a pin already used by another special function
// RULE10 - host drives its chip select only into the device select input
// RULE11 - data out released whenever the device is not the addressed target
// RULE12 - select pulses go to enabled pins ascending, then to the device
// RULE13 - rotation repeats until chained mode is disabled or changed
// RULE14 - forwarded slot copies host select pulse onto that chained pin
// RULE15 - checksummed frames pass unchanged; select is forwarded untouched
// RULE16 - direction bit n controls pin n
// RULE17 - data register drives outputs, inputs read back the sampled level
// RULE18 - in a forwarded slot the device ignores data in, keeps data out off
// RULE19 - chained pins idle high outside their own slot
`ifndef GCS_MAP_SVH
`define GCS_MAP_SVH
`define GCS_NPINS          7
`define GCS_CLK_PIN        4
`define GCS_SYS_HZ         100000000
`define GCS_MASTER_HZ      1000000
`define GCS_CHOP_HZ        125000
`define GCS_MASTER_DIV     (`GCS_SYS_HZ / `GCS_MASTER_HZ)
`define GCS_CHOP_DIV       (`GCS_MASTER_HZ / `GCS_CHOP_HZ)
`define GCS_DIV_W          5
`define GCS_DIR_RST        7'h00
`define GCS_DATA_RST       7'h00
`define GCS_MASK_RST       7'h00
`endif

// ---- rtl/gcs_pkg.sv ----
// Purpose: types for the pin clock and chained select block
// Assumes: nothing
// Notes:   pin vectors are seven bits wide
package gcs_pkg;
    typedef logic [6:0] gcs_pins_t;
    typedef logic [4:0] gcs_div_t;
    typedef enum logic [2:0] {
        GCS_IDLE   = 3'b001,
        GCS_ACTIVE = 3'b010,
        GCS_ADV    = 3'b100
    } gcs_slot_e;
endpackage

// ---- rtl/gcs_sync3.sv ----
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to i_clk
// Notes:   output changes when stages two and three agree
module gcs_sync3 (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_rst_val,
    input  wire logic i_d,
    output logic      o_q
);
    logic s1_reg, s2_reg, s3_reg, q_reg;
    logic s1_next, s2_next, s3_next, q_next;
    always_comb begin
        s1_next = i_d;
        s2_next = s1_reg;
        s3_next = s2_reg;
        q_next  = (s2_reg == s3_reg) ? s3_reg : q_reg;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_reg  <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            q_reg  <= q_next;
        end
    end
    assign o_q = q_reg ^ i_rst_val;
endmodule

// ---- rtl/gcs_clkgen.sv ----
// Purpose: internal master and chopping clock generation
// Assumes: 100 MHz i_clk
// Notes:   levels are 50 percent duty squares, ticks are one-cycle enables
`include "gcs_map.svh"
module gcs_clkgen (
    input  wire logic i_clk,
    input  wire logic i_rst,
    output logic      o_master_lvl,
    output logic      o_master_tick,
    output logic      o_chop_lvl
);
    localparam logic [6:0] HALF_M = 7'(`GCS_MASTER_DIV / 2 - 1);
    localparam logic [2:0] HALF_C = 3'(`GCS_CHOP_DIV / 2 - 1);
    logic [6:0] cnt_reg, cnt_next;
    logic [2:0] ccnt_reg, ccnt_next;
    logic       m_reg, m_next, c_reg, c_next, t_next, t_reg;
    // divide 100 MHz to 1 MHz, then by 8 to 125 kHz
    always_comb begin
        cnt_next  = cnt_reg + 7'h01;
        ccnt_next = ccnt_reg;
        m_next    = m_reg;
        c_next    = c_reg;
        t_next    = 1'b0;
        if (cnt_reg == HALF_M) begin // [RULE1]
            cnt_next = 7'h00;
            m_next   = ~m_reg;
            if (m_reg) begin
                t_next    = 1'b1;
                ccnt_next = ccnt_reg + 3'h1;
                if (ccnt_reg == HALF_C) begin // [RULE1]
                    ccnt_next = 3'h0;
                    c_next    = ~c_reg;
                end
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg  <= 7'h00;
            ccnt_reg <= 3'h0;
            m_reg    <= 1'b0;
            c_reg    <= 1'b0;
            t_reg    <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            ccnt_reg <= ccnt_next;
            m_reg    <= m_next;
            c_reg    <= c_next;
            t_reg    <= t_next;
        end
    end
    assign o_master_lvl  = m_reg;
    assign o_master_tick = t_reg;
    assign o_chop_lvl    = c_reg;
endmodule

// ---- rtl/gcs_top.sv ----
// Purpose: pin special functions: clock out, clock in, chained chip select
// Assumes: control bits are plain ports held by the serial register logic
// Notes:   pins are input, output and output enable triples
`include "gcs_map.svh"
module gcs_top (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire gcs_pkg::gcs_pins_t i_pin_dir,
    input  wire gcs_pkg::gcs_pins_t i_pin_data,
    input  wire gcs_pkg::gcs_pins_t i_chained_select_mask,
    input  wire gcs_pkg::gcs_pins_t i_special_function_config,
    input  wire logic              i_internal_clock_out_enable,
    input  wire logic              i_external_clock_in_enable,
    input  wire logic              i_clock_out_select,
    input  wire logic              i_sync_edge_polarity,
    input  wire gcs_pkg::gcs_div_t  i_clock_divider_field,
    input  wire gcs_pkg::gcs_pins_t i_pin_in,
    output gcs_pkg::gcs_pins_t      o_pin_out,
    output gcs_pkg::gcs_pins_t      o_pin_oe,
    output gcs_pkg::gcs_pins_t      o_pin_read,
    input  wire logic              i_cs_n,
    input  wire logic              i_sdo_core,
    input  wire logic              i_sdo_core_en,
    output logic                   o_sdo_out,
    output logic                   o_sdo_oe,
    output logic                   o_self_cs_n,
    output logic                   o_self_slot,
    output logic                   o_ext_sync_tick,
    output logic                   o_master_tick,
    output logic                   o_chop_lvl
);
    import gcs_pkg::*;

    // ==========================================
    // internal clocks
    logic master_lvl, master_tick_int, chop_lvl;
    gcs_clkgen u_clkgen (
        .i_clk         (i_clk),
        .i_rst         (i_rst),
        .o_master_lvl  (master_lvl),
        .o_master_tick (master_tick_int),
        .o_chop_lvl    (chop_lvl)
    );

    // ==========================================
    // pin input synchronisers
    gcs_pins_t pin_sync;
    logic      cs_n_sync;
    genvar g;
    generate
        for (g = 0; g < `GCS_NPINS; g++) begin : g_sync
            gcs_sync3 u_s (
                .i_clk     (i_clk),
                .i_rst     (i_rst),
                .i_rst_val (1'b0),
                .i_d       (i_pin_in[g]),
                .o_q       (pin_sync[g])
            );
        end
    endgenerate
    // select idles high, so the filter stores it inverted
    logic cs_inv;
    gcs_sync3 u_cs (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_rst_val (1'b1),
        .i_d       (~i_cs_n),
        .o_q       (cs_inv)
    );
    assign cs_n_sync = cs_inv;

    // ==========================================
    // clock pin modes
    logic clk_out_mode, clk_in_mode;
    assign clk_out_mode = i_pin_dir[`GCS_CLK_PIN] & i_internal_clock_out_enable
                        & ~i_external_clock_in_enable; // [RULE2]
    assign clk_in_mode  = ~i_pin_dir[`GCS_CLK_PIN] & i_external_clock_in_enable
                        & ~i_internal_clock_out_enable; // [RULE4]

    // ==========================================
    // external clock edge detect and divider
    logic     ext_prev_reg, ext_prev_next;
    gcs_div_t div_cnt_reg, div_cnt_next;
    logic     sync_tick_reg, sync_tick_next;
    logic     ext_edge;
    // inputs faster than the synchroniser can follow are out of range
    assign ext_edge = i_sync_edge_polarity ?
                      (pin_sync[`GCS_CLK_PIN] & ~ext_prev_reg) :
                      (~pin_sync[`GCS_CLK_PIN] & ext_prev_reg); // [RULE7] [RULE5]
    always_comb begin
        ext_prev_next  = pin_sync[`GCS_CLK_PIN];
        div_cnt_next   = div_cnt_reg;
        sync_tick_next = 1'b0;
        if (!clk_in_mode) begin
            div_cnt_next = '0;
        end else if (ext_edge) begin
            // divider of 0 or 1 passes every edge
            if (div_cnt_reg + 5'h01 >= i_clock_divider_field) begin // [RULE6]
                div_cnt_next   = '0;
                sync_tick_next = 1'b1;
            end else begin
                div_cnt_next = div_cnt_reg + 5'h01;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_prev_reg  <= 1'b0;
            div_cnt_reg   <= '0;
            sync_tick_reg <= 1'b0;
        end else begin
            ext_prev_reg  <= ext_prev_next;
            div_cnt_reg   <= div_cnt_next;
            sync_tick_reg <= sync_tick_next;
        end
    end

    // ==========================================
    // chained select slot sequencer
    gcs_pins_t chain_en;
    assign chain_en = i_chained_select_mask & i_pin_dir
                    & ~i_special_function_config; // [RULE8] [RULE9]

    function automatic logic [2:0] next_slot(input gcs_pins_t en, input logic [2:0] cur,
                                             input logic from_self);
        logic [2:0] r;
        logic       found;
        r     = 3'd7;
        found = 1'b0;
        for (int i = 0; i < `GCS_NPINS; i++) begin
            if (!found && en[i] && (from_self || i > int'(cur))) begin
                r     = 3'(i);
                found = 1'b1;
            end
        end
        return r;
    endfunction

    gcs_slot_e  st_reg, st_next;
    logic [2:0] slot_reg, slot_next;      // 7 means the device itself
    gcs_pins_t  cfg_reg, cfg_next;
    always_comb begin
        st_next   = st_reg;
        slot_next = slot_reg;
        cfg_next  = chain_en;
        unique case (st_reg)
            GCS_IDLE: begin
                if (chain_en != cfg_reg) begin
                    slot_next = next_slot(chain_en, 3'd0, 1'b1); // [RULE13]
                end else if (!cs_n_sync) begin
                    st_next = GCS_ACTIVE;
                end
            end
            GCS_ACTIVE: begin
                if (cs_n_sync) begin
                    st_next = GCS_ADV;
                end
            end
            GCS_ADV: begin
                st_next   = GCS_IDLE;
                slot_next = next_slot(chain_en, slot_reg, slot_reg == 3'd7); // [RULE12] [RULE13]
            end
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg   <= GCS_IDLE;
            slot_reg <= 3'd7;
            cfg_reg  <= `GCS_MASK_RST;
        end else begin
            st_reg   <= st_next;
            slot_reg <= slot_next;
            cfg_reg  <= cfg_next;
        end
    end

    logic self_slot;
    assign self_slot = (slot_reg == 3'd7);
    assign o_self_slot = self_slot;
    // select passes straight through in the device slot, framing and checksums untouched
    assign o_self_cs_n = self_slot ? i_cs_n : 1'b1; // [RULE15] [RULE18] [RULE10]
    assign o_sdo_out   = i_sdo_core;
    assign o_sdo_oe    = self_slot & i_sdo_core_en & ~i_cs_n; // [RULE11] [RULE18]

    // ==========================================
    // pin output drive
    gcs_pins_t out_reg, out_next, read_reg, read_next;
    always_comb begin
        for (int i = 0; i < `GCS_NPINS; i++) begin
            if (chain_en[i]) begin
                out_next[i] = (st_reg != GCS_IDLE && slot_reg == 3'(i)) ?
                              cs_n_sync : 1'b1; // [RULE14] [RULE19]
            end else begin
                out_next[i] = i_pin_data[i]; // [RULE17]
            end
        end
        if (clk_out_mode) begin
            out_next[`GCS_CLK_PIN] = i_clock_out_select ? chop_lvl : master_lvl; // [RULE3]
        end
        read_next = (i_pin_dir & out_reg) | (~i_pin_dir & pin_sync); // [RULE17]
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            out_reg  <= 7'h7F & ~`GCS_DATA_RST;
            read_reg <= 7'h00;
        end else begin
            out_reg  <= out_next;
            read_reg <= read_next;
        end
    end
    assign o_pin_out       = out_reg;
    assign o_pin_oe        = i_pin_dir; // [RULE16]
    assign o_pin_read      = read_reg;
    assign o_ext_sync_tick = sync_tick_reg;
    assign o_master_tick   = master_tick_int;
    assign o_chop_lvl      = chop_lvl;
endmodule

// ---- tb/gcs_checker.sv ----
// Purpose: port checks for gcs_top
// Assumes: one clock, sync active-high reset
// Notes:   bound to every gcs_top
module gcs_checker (
    input wire logic               i_clk,
    input wire logic               i_rst,
    input wire gcs_pkg::gcs_pins_t i_pin_dir,
    input wire gcs_pkg::gcs_pins_t i_chained_select_mask,
    input wire gcs_pkg::gcs_pins_t i_special_function_config,
    input wire logic               i_internal_clock_out_enable,
    input wire logic               i_external_clock_in_enable,
    input wire logic               i_clock_out_select,
    input wire logic               i_cs_n,
    input wire logic               i_sdo_core,
    input wire logic               i_sdo_core_en,
    input wire gcs_pkg::gcs_pins_t o_pin_out,
    input wire gcs_pkg::gcs_pins_t o_pin_oe,
    input wire logic               o_sdo_out,
    input wire logic               o_sdo_oe,
    input wire logic               o_self_cs_n,
    input wire logic               o_self_slot,
    input wire logic               o_master_tick,
    input wire logic               o_chop_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    import gcs_pkg::*;
    // ====
    // helper state
    logic [9:0] gap_reg, gap_next;
    logic       lvl_reg, seen_reg, seen_next, flip, chop_mode;
    gcs_pins_t  chain_en;
    always_comb begin
        flip      = o_chop_lvl != lvl_reg;
        seen_next = seen_reg | flip;
        gap_next  = flip ? 10'h000 : gap_reg + 10'h001;
        chain_en  = i_chained_select_mask & i_pin_dir & ~i_special_function_config;
        chop_mode = i_pin_dir[4] & i_internal_clock_out_enable
                  & ~i_external_clock_in_enable & i_clock_out_select;
    end
    always_ff @(posedge i_clk) begin
        lvl_reg  <= o_chop_lvl;
        seen_reg <= i_rst ? 1'h0 : seen_next;
        gap_reg  <= i_rst ? 10'h000 : gap_next;
    end
    // ====
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_cs_quiet;
        i_cs_n [*8] ##0 $stable(chain_en);
    endsequence
    sequence s_chop_steady;
        chop_mode [*2] ##0 $stable(o_chop_lvl);
    endsequence
    a_oe_is_dir: assert property (o_pin_oe == i_pin_dir)
        else $error("pin enable differs from direction");
    a_sdo_needs_slot: assert property (
        o_sdo_oe |-> o_self_slot && !i_cs_n && i_sdo_core_en)
        else $error("data out driven outside own slot");
    a_sdo_drive_own: assert property (
        o_self_slot && !i_cs_n && i_sdo_core_en |-> o_sdo_oe)
        else $error("data out not driven in own slot");
    a_sdo_off_away: assert property (!o_self_slot |-> !o_sdo_oe && o_self_cs_n)
        else $error("core touched in forwarded slot");
    a_sdo_data_pass: assert property (o_sdo_oe |-> o_sdo_out == i_sdo_core)
        else $error("data out altered");
    a_self_cs_pass: assert property (o_self_slot |-> o_self_cs_n == i_cs_n)
        else $error("own select not passed");
    a_master_tick_gap: assert property (
        o_master_tick |=> !o_master_tick [*8] ##92 o_master_tick)
        else $error("master tick not every 100 cycles");
    a_chop_half_period: assert property (seen_reg && flip |-> gap_reg == 10'h18F)
        else $error("chop half period not 400 cycles");
    a_chop_on_pin: assert property (s_chop_steady |-> o_pin_out[4] == o_chop_lvl)
        else $error("chop clock missing on clock pin");
    a_chain_idle_high: assert property (
        s_cs_quiet |-> (o_pin_out & chain_en) == chain_en)
        else $error("chained pin low while idle");
endmodule
bind gcs_top gcs_checker u_gcs_checker (.i_clk, .i_rst, .i_pin_dir, .i_chained_select_mask,
    .i_special_function_config, .i_internal_clock_out_enable, .i_external_clock_in_enable,
    .i_clock_out_select, .i_cs_n, .i_sdo_core, .i_sdo_core_en, .o_pin_out, .o_pin_oe,
    .o_sdo_out, .o_sdo_oe, .o_self_cs_n, .o_self_slot, .o_master_tick, .o_chop_lvl);

// ---- tb/gcs_far_side.sv ----
// Purpose: host select driver and chained slaves
// Assumes: slave select lines have pull-ups
// Notes:   reports which party saw each select pulse
module gcs_far_side (
    input  wire logic               i_clk,
    input  wire gcs_pkg::gcs_pins_t i_pin_out,
    input  wire gcs_pkg::gcs_pins_t i_pin_oe,
    input  wire logic               i_self_cs_n,
    output logic                    o_cs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import gcs_pkg::*;
    gcs_pins_t sel_lvl;
    initial o_cs_n = 1'h1;
    // released select lines float up
    assign sel_lvl = (i_pin_oe & i_pin_out) | ~i_pin_oe;
    // ====
    // one host frame on the single select line
    task automatic frame(input int low_cyc, output logic [7:0] seen);
        seen = 8'h00;
        @(posedge i_clk);
        o_cs_n <= 1'h0;
        repeat (low_cyc) begin
            @(negedge i_clk);
            seen = seen | {~i_self_cs_n, ~sel_lvl};
            @(posedge i_clk);
        end
        o_cs_n <= 1'h1;
        repeat (10) @(posedge i_clk);
    endtask
endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for gcs_top
// Assumes: 100 MHz clock
// Notes:   external clock on pin 4 has a 32-cycle period
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import gcs_pkg::*;
    logic      i_clk = 1'h0, i_rst = 1'h1, i_cs_n;
    gcs_pins_t i_pin_dir = 7'h00, i_pin_data = 7'h00, ext_drv = 7'h00;
    gcs_pins_t i_chained_select_mask = 7'h00, i_special_function_config = 7'h00;
    logic      i_internal_clock_out_enable = 1'h0, i_external_clock_in_enable = 1'h0;
    logic      i_clock_out_select = 1'h0, i_sync_edge_polarity = 1'h0;
    logic      i_sdo_core = 1'h1, i_sdo_core_en = 1'h1;
    gcs_div_t  i_clock_divider_field = 5'h01;
    logic [4:0] ext_k = 5'h00;
    gcs_pins_t i_pin_in, o_pin_out, o_pin_oe, o_pin_read;
    logic      o_sdo_out, o_sdo_oe, o_self_cs_n, o_self_slot;
    logic      o_ext_sync_tick, o_master_tick, o_chop_lvl;
    int        error_cnt = 0, checked = 0, cycles = 0;
    // ====
    // pin wires and instances
    assign i_pin_in = (o_pin_oe & o_pin_out)
                    | (~o_pin_oe & {ext_drv[6:5], ext_k[4], ext_drv[3:0]});
    gcs_top u_gcs_top (.i_clk, .i_rst, .i_pin_dir, .i_pin_data, .i_chained_select_mask,
        .i_special_function_config, .i_internal_clock_out_enable, .i_external_clock_in_enable,
        .i_clock_out_select, .i_sync_edge_polarity, .i_clock_divider_field, .i_pin_in,
        .o_pin_out, .o_pin_oe, .o_pin_read, .i_cs_n, .i_sdo_core, .i_sdo_core_en,
        .o_sdo_out, .o_sdo_oe, .o_self_cs_n, .o_self_slot, .o_ext_sync_tick,
        .o_master_tick, .o_chop_lvl);
    gcs_far_side u_gcs_far_side (.i_clk, .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
        .i_self_cs_n(o_self_cs_n), .o_cs_n(i_cs_n));
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        ext_k <= ext_k + 5'h01;
        i_sdo_core <= ext_k[0];
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ====
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cfg(input gcs_pins_t d, v, m, s, input logic [3:0] f, input gcs_div_t dv);
        @(posedge i_clk);
        i_pin_dir <= d;
        i_pin_data <= v;
        i_special_function_config <= s;
        {i_internal_clock_out_enable, i_external_clock_in_enable} <= f[3:2];
        {i_clock_out_select, i_sync_edge_polarity} <= f[1:0];
        i_clock_divider_field <= dv;
        @(posedge i_clk);
        i_chained_select_mask <= m;
        repeat (10) @(posedge i_clk);
    endtask
    task automatic count(input int cyc, input logic tk, input logic pol, output int n);
        logic p;
        n = 0;
        p = o_pin_out[4];
        repeat (cyc) begin
            @(negedge i_clk);
            if (tk && o_ext_sync_tick === 1'h1) begin
                n++;
                check(i_pin_in[4], pol);
            end
            if (!tk && o_pin_out[4] === 1'h1 && p === 1'h0) n++;
            p = o_pin_out[4];
        end
    endtask
    task automatic clk_case(input logic [3:0] f, input gcs_div_t dv, input int cyc, exp);
        int n;
        cfg(f[3] ? 7'h10 : 7'h00, 7'h00, 7'h00, 7'h00, f, dv);
        count(200, ~f[3], f[0], n);
        count(cyc, ~f[3], f[0], n);
        check(n, exp);
    endtask
    task automatic chain(input gcs_pins_t d, m, s, input logic [31:0] exp);
        logic [7:0] seen;
        cfg(d, 7'h7F, m, s, 4'h0, 5'h01);
        for (int i = 0; i < 4; i++) begin
            u_gcs_far_side.frame(12, seen);
            check(seen & {1'h1, m & d & ~s}, exp[31 - 8 * i -: 8]);
        end
    endtask
    // ====
    // main sequence
    initial begin
        repeat (10) @(negedge i_clk);
        check(o_pin_out, 7'h7F);
        check(o_pin_read, 7'h00);
        check(o_self_slot, 1'h1);
        @(posedge i_clk);
        i_rst <= 1'h0;
        cfg(7'h1F, 7'h15, 7'h00, 7'h00, 4'h0, 5'h01);
        ext_drv <= 7'h60;
        repeat (10) @(negedge i_clk);
        check(o_pin_read, 7'h75);
        check(o_pin_out & o_pin_oe, 7'h15);
        clk_case(4'h8, 5'h01, 1000, 10);
        clk_case(4'hA, 5'h01, 1600, 2);
        clk_case(4'hC, 5'h01, 1000, 0);
        clk_case(4'h5, 5'h01, 128, 4);
        clk_case(4'h4, 5'h00, 128, 4);
        clk_case(4'h5, 5'h03, 384, 4);
        clk_case(4'h4, 5'h02, 256, 4);
        chain(7'h03, 7'h03, 7'h00, 32'h01028001);
        chain(7'h03, 7'h03, 7'h01, 32'h02800280);
        chain(7'h02, 7'h03, 7'h00, 32'h02800280);
        chain(7'h7F, 7'h44, 7'h00, 32'h04408004);
        chain(7'h00, 7'h00, 7'h00, 32'h80808080);
        tally_and_finish();
    end
endmodule
